/* logic/bcsa_top.sv */
// Purpose: bit-clear and workspace shift execution datapath with an avalon register slave
// Assumes: software loads instruction and operands, then writes the start bit
// Notes:   shifts run one position per clock; byte ops work on the high byte
module bcsa_top
    import bcsa_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // status pins
    output logic             busy,
    output logic      [15:0] processor_flags
);
    import bcsa_pkg::*;

    // opcode decode shared by the step select and the state machine
    function automatic logic is_shift(input logic [15:0] ins);
        is_shift = (ins[15:8] == OP_ARS) || (ins[15:8] == OP_LRS) || (ins[15:8] == OP_LSZ);
    endfunction : is_shift

    function automatic logic [1:0] shift_mode(input logic [15:0] ins);
        case (ins[15:8])
            OP_ARS:  shift_mode = 2'd0;
            OP_LRS:  shift_mode = 2'd1;
            default: shift_mode = 2'd2;
        endcase
    endfunction : shift_mode

    // operand, result and status registers
    bcsa_state_t state_ff, nxt_state;
    logic [15:0] instr_ff, nxt_instr;
    logic [15:0] src_ff, nxt_src;
    logic [15:0] dst_ff, nxt_dst;
    logic [15:0] wr0_ff, nxt_wr0;
    logic        dreg_ff, nxt_dreg;
    logic [15:0] flags_ff, nxt_flags;
    logic [15:0] result_ff, nxt_result;
    logic [4:0]  cnt_ff, nxt_cnt;
    logic        schg_ff, nxt_schg;
    logic        cy_ff, nxt_cy;
    logic        wait_ff, nxt_wait;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        busy_ff, nxt_busy;
    logic        done_ff, nxt_done;

    // combinational answers of the two units
    logic [15:0] lu_res;
    logic        lu_lgt, lu_agt, lu_eq, lu_par;
    logic [15:0] sh_out;
    logic        sh_cy, sh_chg;
    logic        is_bw, is_bb;
    logic [3:0]  fcnt;

    bcsa_logic_unit u_logic (
        .src        (src_ff),
        .dst        (dst_ff),
        .byte_op    (is_bb),
        .dst_is_reg (dreg_ff),
        .res        (lu_res),
        .lgt        (lu_lgt),
        .agt        (lu_agt),
        .eq         (lu_eq),
        .par        (lu_par)
    );

    // one position per clock: small, but a shift
    // of n positions keeps busy high for n+2 cycles
    bcsa_shift_step u_step (
        .din      (result_ff),
        .mode     (shift_mode(instr_ff)),
        .dout     (sh_out),
        .cout     (sh_cy),
        .sign_chg (sh_chg)
    );

    assign is_bw = instr_ff[15:12] == OP_BCLR_WORD;
    assign is_bb = instr_ff[15:12] == OP_BCLR_BYTE;
    assign fcnt  = instr_ff[CNT_LSB +: 4];

    // one wait cycle per access so read data come from a register
    always_comb
    begin
        nxt_wait  = 1'b1;
        nxt_rdata = rdata_ff;
        if ((avs_read || avs_write) && wait_ff)
        begin
            nxt_wait = 1'b0;
            // read data prepared while waitrequest is still high
            if (avs_read)
            begin
                case (avs_address)
                    A_INSTR:  nxt_rdata = {16'h0000, instr_ff};
                    A_SRC:    nxt_rdata = {16'h0000, src_ff};
                    A_DST:    nxt_rdata = {16'h0000, dst_ff};
                    A_WR0:    nxt_rdata = {16'h0000, wr0_ff};
                    A_CTRL:   nxt_rdata = {29'h0, done_ff, dreg_ff, busy_ff};
                    A_FLAGS:  nxt_rdata = {16'h0000, flags_ff};
                    A_RESULT: nxt_rdata = {16'h0000, result_ff};
                    default:  nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // writes land only at the edge that sees waitrequest low
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_instr  = instr_ff;
        nxt_src    = src_ff;
        nxt_dst    = dst_ff;
        nxt_wr0    = wr0_ff;
        nxt_dreg   = dreg_ff;
        nxt_flags  = flags_ff;
        nxt_result = result_ff;
        nxt_cnt    = cnt_ff;
        nxt_schg   = schg_ff;
        nxt_cy     = cy_ff;
        nxt_busy   = busy_ff;
        nxt_done   = done_ff;

        // writes while an operation runs are dropped
        if (avs_write && !wait_ff && !busy_ff)
        begin
            case (avs_address)
                A_INSTR: nxt_instr = avs_writedata[15:0];
                A_SRC:   nxt_src   = avs_writedata[15:0];
                A_DST:   nxt_dst   = avs_writedata[15:0];
                A_WR0:   nxt_wr0   = avs_writedata[15:0];
                A_FLAGS: nxt_flags = avs_writedata[15:0];
                A_CTRL:
                begin
                    nxt_dreg = avs_writedata[1];
                    if (avs_writedata[0])
                    begin
                        nxt_busy  = 1'b1;
                        nxt_done  = 1'b0;
                        nxt_state = BCSA_SHFT;
                    end
                end
                default: nxt_instr = instr_ff;
            endcase
        end

        case (state_ff)
            BCSA_IDLE:
            begin
                nxt_state = nxt_state;
            end
            BCSA_SHFT:
            begin
                if (is_bw || is_bb)
                begin
                    // one pass, the source register is never written
                    nxt_result = lu_res;
                    nxt_flags[FL_LGT] = lu_lgt;
                    nxt_flags[FL_AGT] = lu_agt;
                    nxt_flags[FL_EQ]  = lu_eq;
                    if (is_bb)
                        nxt_flags[FL_PAR] = lu_par;
                    nxt_state = BCSA_DONE;
                end
                else if (is_shift(instr_ff) && cnt_ff == 5'h00)
                begin
                    // first pass: load operand and pick the count
                    // count latched once, so it cannot move mid-shift
                    nxt_result = dst_ff;
                    nxt_schg   = 1'b0;
                    nxt_cy     = 1'b0;
                    if (fcnt != 4'h0)
                        nxt_cnt = {1'b0, fcnt};
                    else if (wr0_ff[3:0] != 4'h0)
                        nxt_cnt = {1'b0, wr0_ff[3:0]};
                    else
                        nxt_cnt = FULL_SHIFT;
                    nxt_state = BCSA_IDLE;
                end
                else
                begin
                    nxt_state = BCSA_DONE;
                end
                if (is_shift(instr_ff) && cnt_ff == 5'h00)
                    nxt_state = BCSA_SHFT;
                if (is_shift(instr_ff) && cnt_ff != 5'h00)
                begin
                    nxt_result = sh_out;
                    nxt_cy     = sh_cy;
                    nxt_schg   = schg_ff | sh_chg;
                    nxt_cnt    = cnt_ff - 5'h01;
                    nxt_state  = (cnt_ff == 5'h01) ? BCSA_DONE : BCSA_SHFT;
                end
                if (is_shift(instr_ff) && cnt_ff == 5'h00 && nxt_cnt == 5'h00)
                    nxt_state = BCSA_DONE;
            end
            BCSA_DONE:
            begin
                // shift flags land together once the last step is in
                if (is_shift(instr_ff))
                begin
                    nxt_flags[FL_LGT] = result_ff != 16'h0000;
                    nxt_flags[FL_AGT] = (result_ff != 16'h0000) && !result_ff[15];
                    nxt_flags[FL_EQ]  = result_ff == 16'h0000;
                    nxt_flags[FL_C]   = cy_ff;
                    // right shifts leave the sign-change flag alone
                    if (shift_mode(instr_ff) == 2'd2)
                        nxt_flags[FL_SCH] = schg_ff;
                end
                nxt_busy  = 1'b0;
                nxt_done  = 1'b1;
                nxt_state = BCSA_IDLE;
            end
            default:
            begin
                nxt_state = BCSA_IDLE;
            end
        endcase
    end

    // operation and register state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff  <= BCSA_IDLE;
            instr_ff  <= 16'h0000;
            src_ff    <= 16'h0000;
            dst_ff    <= 16'h0000;
            wr0_ff    <= 16'h0000;
            dreg_ff   <= 1'b0;
            flags_ff  <= FLAGS_RST;
            result_ff <= 16'h0000;
            cnt_ff    <= 5'h00;
            schg_ff   <= 1'b0;
            cy_ff     <= 1'b0;
            busy_ff   <= 1'b0;
            done_ff   <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            instr_ff  <= nxt_instr;
            src_ff    <= nxt_src;
            dst_ff    <= nxt_dst;
            wr0_ff    <= nxt_wr0;
            dreg_ff   <= nxt_dreg;
            flags_ff  <= nxt_flags;
            result_ff <= nxt_result;
            cnt_ff    <= nxt_cnt;
            schg_ff   <= nxt_schg;
            cy_ff     <= nxt_cy;
            busy_ff   <= nxt_busy;
            done_ff   <= nxt_done;
        end
    end

    // bus handshake state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs come straight from registers
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign busy            = busy_ff;
    assign processor_flags = flags_ff;
endmodule : bcsa_top

/* logic/bcsa_pkg.sv */
// Purpose: constants and types for the bit-clear and shift execution datapath
// Assumes: 16-bit words, bit 0 is the most significant bit in the processor's own numbering
// Notes:   register offsets are word addresses on the avalon slave (byte address = 4 * index)
package bcsa_pkg;
    localparam int W = 16;

    // opcode bases (top bits of the instruction)
    localparam logic [3:0] OP_BCLR_WORD = 4'h4;
    localparam logic [3:0] OP_BCLR_BYTE = 4'h5;
    localparam logic [7:0] OP_ARS       = 8'h08;
    localparam logic [7:0] OP_LRS       = 8'h09;
    localparam logic [7:0] OP_LSZ       = 8'h0a;

    // shift format fields in lsb-0 numbering: count in msb-0 bits 8..11, register in 12..15
    localparam int CNT_LSB = 4;
    localparam int REG_LSB = 0;

    // flag positions, msb-0 numbering turned into lsb-0 index
    localparam int FL_LGT = 15;
    localparam int FL_AGT = 14;
    localparam int FL_EQ  = 13;
    localparam int FL_C   = 12;
    localparam int FL_SCH = 11;
    localparam int FL_PAR = 10;

    localparam logic [4:0] FULL_SHIFT = 5'h10;

    // avalon word offsets
    localparam logic [2:0] A_INSTR  = 3'h0;
    localparam logic [2:0] A_SRC    = 3'h1;
    localparam logic [2:0] A_DST    = 3'h2;
    localparam logic [2:0] A_WR0    = 3'h3;
    localparam logic [2:0] A_CTRL   = 3'h4;
    localparam logic [2:0] A_FLAGS  = 3'h5;
    localparam logic [2:0] A_RESULT = 3'h6;

    localparam logic [15:0] FLAGS_RST = 16'h0000;

    typedef enum logic [1:0] {
        BCSA_IDLE = 2'b00,
        BCSA_SHFT = 2'b01,
        BCSA_DONE = 2'b10
    } bcsa_state_t;
endpackage : bcsa_pkg

/* logic/bcsa_logic_unit.sv */
// Purpose: combinational bit-clear and compare-to-zero for word and byte
// Assumes: byte operands sit in the high byte of a word
// Notes:   result is the full word to store back
module bcsa_logic_unit
    import bcsa_pkg::*;
(
    // operands
    input  wire logic [15:0] src,
    input  wire logic [15:0] dst,
    input  wire logic        byte_op,
    input  wire logic        dst_is_reg,
    // answer
    output logic      [15:0] res,
    output logic             lgt,
    output logic             agt,
    output logic             eq,
    output logic             par
);
    logic [15:0] cleared;
    logic [7:0]  rbyte;

    always_comb
    begin
        cleared = dst & ~src;
        rbyte   = dst[15:8] & ~src[15:8];
        if (byte_op)
        begin
            // low byte kept as fetched, for a workspace register and a memory operand alike
            res = dst_is_reg ? {rbyte, dst[7:0]} : {rbyte, dst[7:0]};
            lgt = rbyte != 8'h00;
            agt = (rbyte != 8'h00) && !rbyte[7];
            eq  = rbyte == 8'h00;
            par = ^rbyte;
        end
        else
        begin
            res = cleared;
            lgt = cleared != 16'h0000;
            agt = (cleared != 16'h0000) && !cleared[15];
            eq  = cleared == 16'h0000;
            par = 1'b0;
        end
    end
endmodule : bcsa_logic_unit

/* logic/bcsa_shift_step.sv */
// Purpose: one single-position shift step with carry and sign-change detect
// Assumes: mode 0 arithmetic right, 1 logical right, 2 left zero fill
// Notes:   iterated by the top one position per clock
module bcsa_shift_step
    import bcsa_pkg::*;
(
    // operand
    input  wire logic [15:0] din,
    input  wire logic [1:0]  mode,
    // answer
    output logic      [15:0] dout,
    output logic             cout,
    output logic             sign_chg
);
    always_comb
    begin
        dout     = din;
        cout     = 1'b0;
        sign_chg = 1'b0;
        case (mode)
            2'd0:
            begin
                dout = {din[15], din[15:1]};
                cout = din[0];
            end
            2'd1:
            begin
                dout = {1'b0, din[15:1]};
                cout = din[0];
            end
            2'd2:
            begin
                dout     = {din[14:0], 1'b0};
                cout     = din[15];
                sign_chg = din[15] ^ din[14];
            end
            default:
            begin
                dout = din;
            end
        endcase
    end
endmodule : bcsa_shift_step

/* sim/bcsa_checker_assertions.sv */
// Purpose: port-level checks of the bit-clear and shift datapath
// Assumes: instruction register written while idle, one access at a time
// Notes:   op latencies are bounded loosely, the bench only waits for busy to fall
module bcsa_checker
    import bcsa_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // status pins
    input  wire logic        busy,
    input  wire logic [15:0] processor_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] code_ff;
    logic [7:0] nxt_code;
    logic       acc;
    logic       ctl_go;
    logic       fl_w;
    assign acc    = avs_read | avs_write;
    assign ctl_go = avs_write & !avs_waitrequest & (avs_address == A_CTRL) & avs_writedata[0];
    assign fl_w   = avs_write & !avs_waitrequest & (avs_address == A_FLAGS);
    // writes while busy are dropped, so track only idle writes
    always_comb
        nxt_code = (avs_write && !avs_waitrequest && avs_address == A_INSTR && !busy)
                   ? avs_writedata[15:8] : code_ff;
    always_ff @(posedge clk)
        code_ff <= rst ? 8'h00 : nxt_code;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_req;
        acc && avs_waitrequest;
    endsequence
    sequence s_ans;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    wait_answer_a: assert property (s_req |=> s_ans) else $error("waitrequest answer wrong");
    wait_cause_a: assert property (!avs_waitrequest |-> $past(acc)) else $error("waitrequest low without access");
    upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("read upper half not zero");
    hole_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 3'h7 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    busy_cause_a: assert property ($rose(busy) |-> ctl_go || $past(ctl_go)) else $error("busy without start");
    busy_bound_a: assert property ($rose(busy) |-> ##[1:20] !busy) else $error("op too long");
    right_keep_a: assert property (((code_ff == OP_ARS) || (code_ff == OP_LRS)) && (busy || $past(busy))
        |-> $stable(processor_flags[FL_SCH])) else $error("right shift touched overflow");
    clear_keep_a: assert property ((code_ff[7:4] == OP_BCLR_WORD || code_ff[7:4] == OP_BCLR_BYTE)
        && (busy || $past(busy)) |-> $stable(processor_flags[FL_C:FL_SCH])) else $error("bit clear touched carry");
    flags_cause_a: assert property ($changed(processor_flags) |-> $past(busy) || $past(busy, 2) || $past(fl_w))
        else $error("flags changed without cause");
endmodule : bcsa_checker

bind bcsa_top bcsa_checker i_chk (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy(busy), .processor_flags(processor_flags));

/* sim/bcsa_avm_model.sv */
// Purpose: avalon master standing in for the processor operand path
// Assumes: one access at a time, answer waited for without a count
// Notes:   released address and data lines are inverted so stale values cannot pass
module bcsa_avm_model
(
    // clock
    input  wire logic        clk,
    // avalon master side
    output logic      [2:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        avs_address   = 3'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0000_0000;
    end
    task automatic xfer(input logic rd, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address   <= a;
        avs_read      <= rd;
        avs_write     <= !rd;
        avs_writedata <= d;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_writedata <= ~d;
        avs_address   <= ~a;
    endtask : xfer
endmodule : bcsa_avm_model

/* sim/bit_clear_and_shift_alu_test.sv */
// Purpose: self-checking bench for the bit-clear and shift datapath
// Assumes: flags preloaded before each op so kept bits are known
// Notes:   rows hold operands and the result and flags they must give
module bit_clear_and_shift_alu_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bcsa_pkg::*;
    typedef struct packed {
        logic [15:0] ins, src, dst, wr0, pre;
        logic        rg;
        logic [15:0] res, fl;
    } bcsa_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  adr;
    logic        rd_s, wr_s, wait_r, busy;
    logic [31:0] wd, rdat, q;
    logic [15:0] flags;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    bcsa_row_t   rows [14] = '{
        '{16'h4143, 16'h6d03, 16'hd2aa, 16'h0000, 16'h0000, 1'b1, 16'h92a8, 16'h8000},
        '{16'h4000, 16'hffff, 16'h1234, 16'h0000, 16'h1c00, 1'b1, 16'h0000, 16'h3c00},
        '{16'h5000, 16'hf018, 16'haa24, 16'h0000, 16'h0000, 1'b0, 16'h0a24, 16'hc000},
        '{16'h5000, 16'h0f00, 16'h87ab, 16'h0000, 16'h1800, 1'b1, 16'h80ab, 16'h9c00},
        '{16'h5000, 16'hff00, 16'h12ff, 16'h0000, 16'h0400, 1'b1, 16'h00ff, 16'h2000},
        '{16'h0805, 16'h0000, 16'h8224, 16'hf326, 16'h0000, 1'b1, 16'hfe08, 16'h9000},
        '{16'h0800, 16'h0000, 16'h8000, 16'hf320, 16'h0800, 1'b1, 16'hffff, 16'h9800},
        '{16'h0842, 16'h0000, 16'h7ffe, 16'h0003, 16'h0000, 1'b1, 16'h07ff, 16'hd000},
        '{16'h0a5a, 16'h0000, 16'h1357, 16'h0000, 16'h0000, 1'b1, 16'h6ae0, 16'hc800},
        '{16'h0a11, 16'h0000, 16'h4000, 16'h0000, 16'h1000, 1'b1, 16'h8000, 16'h8800},
        '{16'h0af0, 16'h0000, 16'h0003, 16'h0000, 16'h0000, 1'b1, 16'h8000, 16'h9800},
        '{16'h0a21, 16'h0000, 16'h0001, 16'h0000, 16'h0800, 1'b1, 16'h0004, 16'hc000},
        '{16'h0900, 16'h0000, 16'hffef, 16'h0003, 16'h0000, 1'b1, 16'h1ffd, 16'hd000},
        '{16'h0900, 16'h0000, 16'h8000, 16'h0000, 16'h0400, 1'b1, 16'h0000, 16'h3400}};

    always #10 clk = ~clk;

    bcsa_top i_dut (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_r), .busy(busy), .processor_flags(flags));
    bcsa_avm_model i_host (.clk(clk), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wait_r));

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        logic [31:0] t;
        i_host.xfer(1'b0, a, {16'h0000, d}, t);
    endtask : wr
    task automatic rd(input logic [2:0] a);
        i_host.xfer(1'b1, a, 32'h0000_0000, q);
    endtask : rd
    task automatic go(input bcsa_row_t r);
        wr(A_INSTR, r.ins);
        wr(A_SRC, r.src);
        wr(A_DST, r.dst);
        wr(A_WR0, r.wr0);
        wr(A_FLAGS, r.pre);
        wr(A_CTRL, {14'h0000, r.rg, 1'b1});
        #1;
        chk("busy start", {15'h0000, busy}, 16'h0001);
    endtask : go
    task automatic fin(input bcsa_row_t r);
        do
            @(posedge clk);
        while (busy !== 1'b0);
        rd(A_RESULT);
        chk("result", q[15:0], r.res);
        rd(A_FLAGS);
        chk("flags", q[15:0], r.fl);
        rd(A_SRC);
        chk("source", q[15:0], r.src);
    endtask : fin

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            summarize();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(A_FLAGS);
        chk("reset flags", q[15:0], FLAGS_RST);
        chk("reset busy", {15'h0000, busy}, 16'h0000);
        $display("test reset done");
        foreach (rows[i])
        begin
            go(rows[i]);
            fin(rows[i]);
            $display("test row %0d done", i);
        end
        rd(3'h7);
        chk("unmapped", q[15:0], 16'h0000);
        wr(A_RESULT, 16'hbeef);
        rd(A_RESULT);
        chk("result ro", q[15:0], rows[13].res);
        $display("test map done");
        // writes landing mid-shift must not disturb the run
        go(rows[6]);
        wr(A_FLAGS, 16'h00ff);
        wr(A_DST, 16'h1111);
        fin(rows[6]);
        $display("test busy write done");
        go(rows[6]);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("mid reset busy", {15'h0000, busy}, 16'h0000);
        rd(A_FLAGS);
        chk("mid reset flags", q[15:0], FLAGS_RST);
        $display("test mid reset done");
        summarize();
    end
endmodule : bit_clear_and_shift_alu_test
